/* hdl/eep_ctrl.v */
/*
  Serial EEPROM host-command engine with APB register access, automatic
  load after reset into a 512-byte descriptor memory, and ready polling
  with timeout for erase and write commands.
  Assumes an APB master on clk_i and a three-wire serial EEPROM whose
  data-out pin is asynchronous to clk_i.
*/
// The register offsets and register access over APB were left to the implementer.
`include "eep_consts.vh"

module eep_ctrl
#(
  parameter ADDR_W = 7,
  parameter MEM_BYTES = 512,
  parameter TIMEOUT_CYC = `EEP_TIMEOUT_CYC
)
(
  input wire clk_i, // 100 MHz system clock
  input wire soft_reset_request_i, // synchronous reset, active high
  input wire psel_i, // APB select
  input wire penable_i, // APB enable
  input wire pwrite_i, // APB direction, high for write
  input wire [7:0] paddr_i, // APB byte address
  input wire [31:0] pwdata_i, // APB write data
  output reg [31:0] prdata_o, // APB read data
  output reg pready_o, // APB ready
  output reg pslverr_o, // APB error, unmapped address
  output wire mem_clk_o, // serial_memory_clock
  output reg mem_cs_o, // memory chip select, active high
  output wire mem_do_o, // data to memory
  input wire mem_di_i, // data from memory, asynchronous
  output reg usb_disconnect_o, // hold USB PHY disconnected
  input wire [8:0] desc_addr_i, // descriptor memory read address
  output reg [7:0] desc_data_o // descriptor memory read data
);

localparam S_IDLE = 3'h0;
localparam S_SHIFT = 3'h1;
localparam S_GAP = 3'h2;
localparam S_POLL = 3'h3;

localparam [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};
localparam integer TMO_LAST_I = TIMEOUT_CYC - 1;
localparam integer GAP_LAST_I = `EEP_CS_GAP_CYC - 1;
localparam [21:0] TMO_LAST = TMO_LAST_I[21:0];
localparam [7:0] GAP_LAST = GAP_LAST_I[7:0];

reg [2:0] st_r;
reg busy_r;
reg tmo_r;
reg loaded_r;
reg [2:0] code_r;
reg [ADDR_W-1:0] addr_r;
reg [7:0] data_r;
reg ld_act_r;
reg ld_pend_r;
reg [ADDR_W-1:0] ld_addr_r;
reg [21:0] tmo_cnt_r;
reg [7:0] gap_cnt_r;
reg sh_start_r;
reg [4:0] nbits_r;
reg [`EEP_FRAME_W-1:0] frame_r;
reg [7:0] mem_r [0:MEM_BYTES-1];
reg [8:0] mem_waddr_nxt;

wire di_s;
wire sh_busy;
wire sh_done;
wire [7:0] sh_rx;
wire acc = psel_i & penable_i & pready_o;
wire wr = acc & pwrite_i;
wire hit_cmd = paddr_i == `EEP_OFS_CMD;
wire hit_data = paddr_i == `EEP_OFS_DATA;
wire hit_ctrl = paddr_i == `EEP_OFS_CTRL;
wire needs_poll = code_r == `EEP_C_WRITE || code_r == `EEP_C_WRITE_EVERY_LOCATION ||
  code_r == `EEP_C_ERASE || code_r == `EEP_C_ERASE_EVERY_LOCATION;

// builds start bit, opcode, address and data for each command
function [`EEP_FRAME_W-1:0] mk_frame;
  input [2:0] code;
  input [ADDR_W-1:0] a;
  input [7:0] d;
  reg [6:0] a7;
  begin
    a7 = 7'h00;
    a7[ADDR_W-1:0] = a;
    case (code)
      `EEP_C_READ: mk_frame = {3'b110, a7, 8'h00};
      `EEP_C_WRITE: mk_frame = {3'b101, a7, d};
      `EEP_C_ERASE: mk_frame = {3'b111, a7, 8'h00};
      `EEP_C_ERASE_WRITE_ENABLE: mk_frame = {3'b100, 7'h60, 8'h00};
      `EEP_C_ERASE_WRITE_DISABLE: mk_frame = {3'b100, 7'h00, 8'h00};
      `EEP_C_ERASE_EVERY_LOCATION: mk_frame = {3'b100, 7'h40, 8'h00};
      `EEP_C_WRITE_EVERY_LOCATION: mk_frame = {3'b100, 7'h20, d};
      default: mk_frame = {3'b110, a7, 8'h00};
    endcase
  end
endfunction

// read and all write forms carry a data byte
function [4:0] mk_bits;
  input [2:0] code;
  begin
    case (code)
      `EEP_C_READ, `EEP_C_WRITE, `EEP_C_WRITE_EVERY_LOCATION, `EEP_C_RELOAD: mk_bits = `EEP_BITS_LONG;
      default: mk_bits = `EEP_BITS_SHORT;
    endcase
  end
endfunction

eep_sync u_sync
(
  .clk_i(clk_i),
  .soft_reset_request_i(soft_reset_request_i),
  .d_i(mem_di_i),
  .q_o(di_s)
);

eep_shift u_shift
(
  .clk_i(clk_i),
  .soft_reset_request_i(soft_reset_request_i),
  .start_i(sh_start_r),
  .nbits_i(nbits_r),
  .frame_i(frame_r),
  .miso_i(di_s),
  .sclk_o(mem_clk_o),
  .mosi_o(mem_do_o),
  .busy_o(sh_busy),
  .done_o(sh_done),
  .rx_o(sh_rx)
);

always @*
begin
  mem_waddr_nxt = 9'h000;
  mem_waddr_nxt[ADDR_W-1:0] = ld_addr_r;
end

// one wait state so that read data leaves a flip-flop
always @(posedge clk_i)
begin
  if (soft_reset_request_i)
  begin
    pready_o <= 1'b0;
    pslverr_o <= 1'b0;
    prdata_o <= 32'h00000000;
  end
  else
  begin
    pready_o <= psel_i & penable_i & ~pready_o;
    pslverr_o <= psel_i & penable_i & ~pready_o & ~(hit_cmd | hit_data | hit_ctrl);
    prdata_o <= 32'h00000000;
    if (psel_i & penable_i & ~pready_o & ~pwrite_i)
    begin
      if (hit_cmd)
      begin
        prdata_o[`EEP_CMD_BUSY_BIT] <= busy_r;
        prdata_o[`EEP_CMD_CODE_HI:`EEP_CMD_CODE_LO] <= code_r;
        prdata_o[`EEP_CMD_LOADED_BIT] <= loaded_r;
        prdata_o[`EEP_CMD_TMO_BIT] <= tmo_r;
        prdata_o[ADDR_W-1:0] <= addr_r;
      end
      else if (hit_data)
        prdata_o[7:0] <= data_r;
      else if (hit_ctrl)
      begin
        prdata_o[`EEP_CTRL_LOADING_BIT] <= ld_act_r | ld_pend_r;
        prdata_o[`EEP_CTRL_DISC_BIT] <= usb_disconnect_o;
      end
    end
  end
end

always @(posedge clk_i)
begin
  desc_data_o <= mem_r[desc_addr_i];
  if (ld_act_r & sh_done & (ld_addr_r != {ADDR_W{1'b0}} || sh_rx == `EEP_SIGNATURE))
    mem_r[mem_waddr_nxt] <= sh_rx;
end

always @(posedge clk_i)
begin
  sh_start_r <= 1'b0;
  if (soft_reset_request_i)
  begin
    st_r <= S_IDLE;
    busy_r <= 1'b0;
    tmo_r <= 1'b0;
    loaded_r <= 1'b0;
    code_r <= `EEP_C_READ;
    addr_r <= {ADDR_W{1'b0}};
    data_r <= `EEP_DATA_RST;
    ld_act_r <= 1'b0;
    ld_pend_r <= 1'b1;
    ld_addr_r <= {ADDR_W{1'b0}};
    tmo_cnt_r <= 22'h000000;
    gap_cnt_r <= 8'h00;
    nbits_r <= 5'h00;
    frame_r <= {`EEP_FRAME_W{1'b0}};
    mem_cs_o <= 1'b0;
    usb_disconnect_o <= 1'b1;
  end
  else
  begin
    // command and data register writes are refused while a command is running
    if (wr & hit_cmd & ~busy_r & pwdata_i[`EEP_CMD_BUSY_BIT])
    begin
      busy_r <= 1'b1;
      tmo_r <= 1'b0;
      code_r <= pwdata_i[`EEP_CMD_CODE_HI:`EEP_CMD_CODE_LO];
      addr_r <= pwdata_i[ADDR_W-1:0];
    end
    if (wr & hit_data & ~busy_r)
      data_r <= pwdata_i[7:0];
    if (wr & hit_ctrl & pwdata_i[`EEP_CTRL_SOFT_RESET_REQUEST_BIT])
    begin
      ld_pend_r <= 1'b1;
      usb_disconnect_o <= 1'b1;
    end
    case (st_r)
      S_IDLE:
      begin
        // a pending automatic load runs ahead of any host command
        if (ld_pend_r)
        begin
          ld_pend_r <= 1'b0;
          ld_act_r <= 1'b1;
          ld_addr_r <= {ADDR_W{1'b0}};
          frame_r <= mk_frame(`EEP_C_READ, {ADDR_W{1'b0}}, 8'h00);
          nbits_r <= `EEP_BITS_LONG;
          sh_start_r <= 1'b1;
          mem_cs_o <= 1'b1;
          st_r <= S_SHIFT;
        end
        else if (busy_r)
        begin
          if (code_r == `EEP_C_RELOAD)
          begin
            ld_act_r <= 1'b1;
            loaded_r <= 1'b0;
            ld_addr_r <= {ADDR_W{1'b0}};
          end
          frame_r <= mk_frame(code_r, addr_r, data_r);
          // reload always starts at byte zero, whatever the address field holds
          if (code_r == `EEP_C_RELOAD)
            frame_r <= mk_frame(`EEP_C_READ, {ADDR_W{1'b0}}, 8'h00);
          nbits_r <= mk_bits(code_r);
          sh_start_r <= 1'b1;
          mem_cs_o <= 1'b1;
          st_r <= S_SHIFT;
        end
      end
      S_SHIFT:
      begin
        if (sh_done)
        begin
          mem_cs_o <= 1'b0;
          gap_cnt_r <= 8'h00;
          if (ld_act_r)
          begin
            if (ld_addr_r == {ADDR_W{1'b0}} && sh_rx != `EEP_SIGNATURE)
            begin
              ld_act_r <= 1'b0;
              busy_r <= 1'b0;
              usb_disconnect_o <= 1'b0;
              st_r <= S_IDLE;
            end
            else if (ld_addr_r == LAST_ADDR)
            begin
              ld_act_r <= 1'b0;
              loaded_r <= 1'b1;
              busy_r <= 1'b0;
              usb_disconnect_o <= 1'b0;
              st_r <= S_IDLE;
            end
            else
            begin
              ld_addr_r <= ld_addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
              st_r <= S_GAP;
            end
          end
          else if (needs_poll)
            st_r <= S_GAP;
          else
          begin
            if (code_r == `EEP_C_READ)
              data_r <= sh_rx;
            busy_r <= 1'b0;
            st_r <= S_IDLE;
          end
        end
      end
      S_GAP:
      begin
        // chip select low between frames, and before the ready poll
        if (gap_cnt_r == GAP_LAST)
        begin
          mem_cs_o <= 1'b1;
          tmo_cnt_r <= 22'h000000;
          if (ld_act_r)
          begin
            frame_r <= mk_frame(`EEP_C_READ, ld_addr_r, 8'h00);
            nbits_r <= `EEP_BITS_LONG;
            sh_start_r <= 1'b1;
            st_r <= S_SHIFT;
          end
          else
            st_r <= S_POLL;
        end
        else
          gap_cnt_r <= gap_cnt_r + 8'h01;
      end
      S_POLL:
      begin
        // memory raises its data-out line when programming has finished
        // the synchroniser still shows the line from before select rose
        if (di_s && tmo_cnt_r > 22'h000003)
        begin
          mem_cs_o <= 1'b0;
          busy_r <= 1'b0;
          st_r <= S_IDLE;
        end
        else if (tmo_cnt_r == TMO_LAST)
        begin
          mem_cs_o <= 1'b0;
          tmo_r <= 1'b1;
          busy_r <= 1'b0;
          st_r <= S_IDLE;
        end
        else
          tmo_cnt_r <= tmo_cnt_r + 22'h000001;
      end
      default:
      begin
        mem_cs_o <= 1'b0;
        st_r <= S_IDLE;
      end
    endcase
  end
end

endmodule // eep_ctrl

/* hdl/eep_consts.vh */
/*
  Constants for the serial EEPROM host-command engine: register offsets,
  field positions, reset values, command codes and timing counts.
  Assumes a 100 MHz system clock and a three-wire serial EEPROM with 7-bit
  byte addresses.
*/
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH

// register byte offsets on APB
`define EEP_OFS_CMD 8'h00
`define EEP_OFS_DATA 8'h04
`define EEP_OFS_CTRL 8'h08

// eeprom_command_register field positions
`define EEP_CMD_BUSY_BIT 31
`define EEP_CMD_CODE_HI 30
`define EEP_CMD_CODE_LO 28
`define EEP_CMD_LOADED_BIT 10
`define EEP_CMD_TMO_BIT 9
`define EEP_CMD_ADDR_HI 6
`define EEP_CMD_ADDR_LO 0

// control register fields
`define EEP_CTRL_SOFT_RESET_REQUEST_BIT 0
`define EEP_CTRL_LOADING_BIT 1
`define EEP_CTRL_DISC_BIT 2

// command codes
`define EEP_C_READ 3'h0
`define EEP_C_ERASE_WRITE_DISABLE 3'h1
`define EEP_C_ERASE_WRITE_ENABLE 3'h2
`define EEP_C_WRITE 3'h3
`define EEP_C_WRITE_EVERY_LOCATION 3'h4
`define EEP_C_ERASE 3'h5
`define EEP_C_ERASE_EVERY_LOCATION 3'h6
`define EEP_C_RELOAD 3'h7

// serial frame: start bit, 2-bit opcode, 7-bit address, 8-bit data
`define EEP_FRAME_W 18
`define EEP_BITS_SHORT 5'h0A
`define EEP_BITS_LONG 5'h12
`define EEP_SIGNATURE 8'hA5

// reset values
`define EEP_DATA_RST 8'h00

// timing
`define EEP_CLK_MHZ 100
`define EEP_TIMEOUT_MS 30
`define EEP_TIMEOUT_CYC (`EEP_TIMEOUT_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_SCLK_HALF_NS 400
`define EEP_SCLK_HALF_CYC ((`EEP_SCLK_HALF_NS * `EEP_CLK_MHZ) / 1000)
`define EEP_CS_GAP_NS 250
`define EEP_CS_GAP_CYC ((`EEP_CS_GAP_NS * `EEP_CLK_MHZ + 999) / 1000)

`endif

/* hdl/eep_sync.v */
/*
  Two-stage synchroniser for a level from outside the clock domain.
  Assumes the input changes slowly compared to the clock.
*/
module eep_sync
(
  input wire clk_i, // system clock
  input wire soft_reset_request_i, // synchronous reset, active high
  input wire d_i, // asynchronous level
  output reg q_o // synchronised level
);

reg meta_r;

always @(posedge clk_i)
begin
  if (soft_reset_request_i)
  begin
    meta_r <= 1'b0;
    q_o <= 1'b0;
  end
  else
  begin
    meta_r <= d_i;
    q_o <= meta_r;
  end
end

endmodule // eep_sync

/* hdl/eep_shift.v */
/*
  Serial frame shifter: drives the serial memory clock and data out, MSB
  first, and collects the last eight data-in bits.
  Assumes start_i only pulses while busy_o is low and that data in is
  already synchronised.
*/
`include "eep_consts.vh"

module eep_shift
#(
  parameter HALF = `EEP_SCLK_HALF_CYC
)
(
  input wire clk_i, // system clock
  input wire soft_reset_request_i, // synchronous reset, active high
  input wire start_i, // one-cycle start pulse
  input wire [4:0] nbits_i, // clock cycles to generate
  input wire [`EEP_FRAME_W-1:0] frame_i, // frame, MSB first
  input wire miso_i, // synchronised data from memory
  output reg sclk_o, // serial_memory_clock
  output reg mosi_o, // data to memory
  output reg busy_o, // frame in progress
  output reg done_o, // one-cycle pulse at frame end
  output reg [7:0] rx_o // last eight bits received
);

reg [15:0] div_r;
reg [4:0] left_r;
reg [`EEP_FRAME_W-1:0] sh_r;

always @(posedge clk_i)
begin
  done_o <= 1'b0;
  if (soft_reset_request_i)
  begin
    sclk_o <= 1'b0;
    mosi_o <= 1'b0;
    busy_o <= 1'b0;
    rx_o <= 8'h00;
    div_r <= 16'h0000;
    left_r <= 5'h00;
    sh_r <= {`EEP_FRAME_W{1'b0}};
  end
  else if (start_i)
  begin
    busy_o <= 1'b1;
    sclk_o <= 1'b0;
    div_r <= 16'h0000;
    left_r <= nbits_i;
    mosi_o <= frame_i[`EEP_FRAME_W-1];
    sh_r <= {frame_i[`EEP_FRAME_W-2:0], 1'b0};
  end
  else if (busy_o)
  begin
    if (div_r == HALF[15:0] - 16'h0001)
    begin
      div_r <= 16'h0000;
      sclk_o <= ~sclk_o;
      if (sclk_o)
      begin
        // sample at the end of the high phase, when memory data has settled
        rx_o <= {rx_o[6:0], miso_i};
        mosi_o <= sh_r[`EEP_FRAME_W-1];
        sh_r <= {sh_r[`EEP_FRAME_W-2:0], 1'b0};
        left_r <= left_r - 5'h01;
        if (left_r == 5'h01)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          mosi_o <= 1'b0;
        end
      end
    end
    else
      div_r <= div_r + 16'h0001;
  end
end

endmodule // eep_shift

/* test/eep_mem_model.sv */
/*
  Behavioural serial memory: 128 bytes, write lock, ready polling.
  Assumes 10 or 18 clock frames, MSB first, sampled on the rising clock.
*/
module eep_mem_model
(
  input wire logic clk_i, // paces the ready answer
  input wire logic sclk_i, // serial_memory_clock
  input wire logic cs_i, // select, active high
  input wire logic di_i, // data into memory
  output logic do_o // data out of memory
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:127];
  logic [17:0] sr;
  logic [9:0] hdr;
  logic wen = 1'b0; // powers up locked
  logic pend = 1'b0;
  int cnt = 0, wait_c = 0, ready_cyc = 50;
  initial
  begin
    do_o = 1'b0;
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i);
  end
  always @(posedge cs_i)
  begin
    cnt = 0;
    wait_c = 0;
  end
  always @(posedge sclk_i)
    if (cs_i)
    begin
      sr = {sr[16:0], di_i};
      cnt++;
      if (cnt == 10)
        hdr = sr[9:0];
      if (cnt > 10 && hdr[8:7] == 2'b10)
        do_o <= mem[hdr[6:0]][18 - cnt];
    end
  always @(negedge cs_i)
    if (cnt == 0)
      pend = 1'b0;
    else
      case (hdr[8:7])
        2'b00:
          case (hdr[6:5])
            2'b11: wen = 1'b1;
            2'b00: wen = 1'b0;
            default:
            begin
              pend = 1'b1;
              for (int i = 0; i < 128; i++)
                if (wen)
                  mem[i] = hdr[5] ? sr[7:0] : 8'hFF;
            end
          endcase
        2'b01:
        begin
          pend = 1'b1;
          if (wen)
            mem[hdr[6:0]] = sr[7:0];
        end
        2'b11:
        begin
          pend = 1'b1;
          if (wen)
            mem[hdr[6:0]] = 8'hFF;
        end
        default: ;
      endcase
  // a released line has no level to lean on, so it toggles
  always @(posedge clk_i)
    if (!cs_i)
      do_o <= ~do_o;
    else if (pend && cnt == 0)
    begin
      do_o <= (wait_c >= ready_cyc);
      wait_c++;
    end
endmodule // eep_mem_model

/* test/eep_ctrl_props.sv */
/*
  Port assertions for eep_ctrl: APB answer timing and serial frame shape.
  Assumes one clock domain with synchronous reset.
*/
module eep_ctrl_props
#(
  parameter ADDR_W = 7,
  parameter MEM_BYTES = 512,
  parameter TIMEOUT_CYC = 3000000
)
(
  input wire clk_i, // clock
  input wire soft_reset_request_i, // reset
  input wire psel_i, // select
  input wire penable_i, // enable
  input wire pwrite_i, // direction
  input wire [7:0] paddr_i, // address
  input wire [31:0] pwdata_i, // write data
  input wire [31:0] prdata_o, // read data
  input wire pready_o, // ready
  input wire pslverr_o, // error
  input wire mem_clk_o, // serial clock
  input wire mem_cs_o, // select
  input wire mem_do_o, // data out
  input wire mem_di_i, // data in
  input wire usb_disconnect_o, // disconnect
  input wire [8:0] desc_addr_i, // descriptor address
  input wire [7:0] desc_data_o // descriptor data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (soft_reset_request_i);
  property p_lat;
    (psel_i && !penable_i) ##1 (psel_i && penable_i) |=> pready_o;
  endproperty
  a_lat: assert property (p_lat) else $error("ready not in 2nd access cycle");
  property p_acc;
    pready_o |-> psel_i && penable_i;
  endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err;
    pslverr_o |-> pready_o && prdata_o == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd0;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside answer");
  property p_idle;
    !mem_cs_o |-> !mem_clk_o;
  endproperty
  a_idle: assert property (p_idle) else $error("clock outside frame");
  property p_hi;
    $rose(mem_clk_o) |=> mem_clk_o [*8];
  endproperty
  a_hi: assert property (p_hi) else $error("short high phase");
  property p_lo;
    $fell(mem_clk_o) |-> !mem_clk_o [*8];
  endproperty
  a_lo: assert property (p_lo) else $error("short low phase");
  property p_lead;
    $rose(mem_cs_o) |-> !mem_clk_o [*8];
  endproperty
  a_lead: assert property (p_lead) else $error("clock too soon after select");
  property p_dstb;
    mem_clk_o && $past(mem_clk_o) |-> $stable(mem_do_o);
  endproperty
  a_dstb: assert property (p_dstb) else $error("data moved while clock high");
  property p_disc;
    $fell(soft_reset_request_i) |-> usb_disconnect_o;
  endproperty
  a_disc: assert property (p_disc) else $error("connected during load");
  c_load: cover property ($fell(usb_disconnect_o));
  c_err: cover property (pslverr_o);
  c_frame: cover property ($rose(mem_cs_o));
endmodule // eep_ctrl_props
bind eep_ctrl eep_ctrl_props #(.ADDR_W(ADDR_W), .MEM_BYTES(MEM_BYTES),
  .TIMEOUT_CYC(TIMEOUT_CYC)) u_props (.clk_i(clk_i), .soft_reset_request_i(soft_reset_request_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_clk_o(mem_clk_o),
  .mem_cs_o(mem_cs_o), .mem_do_o(mem_do_o), .mem_di_i(mem_di_i),
  .usb_disconnect_o(usb_disconnect_o), .desc_addr_i(desc_addr_i), .desc_data_o(desc_data_o));

/* test/test_serial_eeprom_host_access.sv */
/*
  Self-checking bench: APB host commands against the serial memory model.
  Assumes the timeout count is shortened to 200 cycles.
*/
`include "eep_consts.vh"
module test_serial_eeprom_host_access;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, soft_reset_request_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, perr;
  logic [7:0] paddr_i = 8'h00, desc_data_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic pready_o, pslverr_o, mem_clk_o, mem_cs_o, mem_do_o, mem_di_i, usb_disconnect_o;
  int fails = 0, checks_done = 0, nclk = 0;
  eep_ctrl #(.TIMEOUT_CYC(200)) uut (.clk_i(clk_i), .soft_reset_request_i(soft_reset_request_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_clk_o(mem_clk_o),
    .mem_cs_o(mem_cs_o), .mem_do_o(mem_do_o), .mem_di_i(mem_di_i),
    .usb_disconnect_o(usb_disconnect_o), .desc_addr_i(9'h000), .desc_data_o(desc_data_o));
  eep_mem_model u_mem (.clk_i(clk_i), .sclk_i(mem_clk_o), .cs_i(mem_cs_o), .di_i(mem_do_o),
    .do_o(mem_di_i));
  always #5 clk_i = ~clk_i;
  always @(posedge mem_clk_o) nclk++;
  task report_and_stop;
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      report_and_stop;
    end
  endtask
  task run_cmd(input logic [2:0] code, input logic [6:0] a, input int clocks);
    int n;
    apb(1'b1, `EEP_OFS_CMD, {1'b1, code, 21'h0, a});
    nclk = 0;
    apb(1'b0, `EEP_OFS_CMD, 32'h0);
    check("busy", q[31], 1'b1);
    n = 0;
    while (q[31] !== 1'b0 && n < 1000)
    begin
      apb(1'b0, `EEP_OFS_CMD, 32'h0);
      n++;
    end
    check("done", n < 1000, 1'b1);
    if (n >= 1000)
      report_and_stop;
    check("clocks", nclk, clocks);
  endtask
  task t_autoload;
    int n;
    check("disconnect", usb_disconnect_o, 1'b1);
    n = 0;
    while (usb_disconnect_o !== 1'b0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    check("load end", n < 3000, 1'b1);
    if (n >= 3000)
      report_and_stop;
    apb(1'b0, `EEP_OFS_CMD, 32'h0);
    check("loaded", q[10], 1'b0);
  endtask
  task t_write_read;
    run_cmd(`EEP_C_ERASE_WRITE_ENABLE, 7'h00, 10);
    apb(1'b1, `EEP_OFS_DATA, 32'h5A);
    run_cmd(`EEP_C_WRITE, 7'h13, 18);
    check("stored", u_mem.mem[19], 8'h5A);
    apb(1'b1, `EEP_OFS_DATA, 32'h0);
    run_cmd(`EEP_C_READ, 7'h13, 18);
    apb(1'b0, `EEP_OFS_DATA, 32'h0);
    check("read", q, 32'h5A);
  endtask
  task t_bulk;
    run_cmd(`EEP_C_ERASE, 7'h13, 10);
    check("erase", u_mem.mem[19], 8'hFF);
    apb(1'b1, `EEP_OFS_DATA, 32'hC3);
    run_cmd(`EEP_C_WRITE_EVERY_LOCATION, 7'h00, 18);
    check("write_every_location", {u_mem.mem[0], u_mem.mem[127]}, 16'hC3C3);
    run_cmd(`EEP_C_ERASE_EVERY_LOCATION, 7'h00, 10);
    check("erase_every_location", u_mem.mem[64], 8'hFF);
    run_cmd(`EEP_C_ERASE_WRITE_DISABLE, 7'h00, 10);
    apb(1'b1, `EEP_OFS_DATA, 32'h11);
    run_cmd(`EEP_C_WRITE, 7'h02, 18);
    check("locked", u_mem.mem[2], 8'hFF);
  endtask
  task t_timeout;
    run_cmd(`EEP_C_ERASE_WRITE_ENABLE, 7'h00, 10);
    u_mem.ready_cyc = 100000;
    run_cmd(`EEP_C_WRITE, 7'h04, 18);
    check("timeout", q[9], 1'b1);
    u_mem.ready_cyc = 50;
    run_cmd(`EEP_C_READ, 7'h04, 18);
    check("timeout clear", q[9], 1'b0);
    apb(1'b0, `EEP_OFS_DATA, 32'h0);
    check("data", q, 32'h11);
  endtask
  task t_reload;
    run_cmd(`EEP_C_RELOAD, 7'h00, 18);
    check("reload fail", q[10], 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped err", perr, 1'b1);
    check("unmapped data", q, 32'h0);
  endtask
  task t_soft;
    int n;
    apb(1'b1, `EEP_OFS_CTRL, 32'h1);
    apb(1'b0, `EEP_OFS_CTRL, 32'h0);
    check("soft disc", q[2:1], 2'b11);
    n = 0;
    while (usb_disconnect_o !== 1'b0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    check("soft end", n < 3000, 1'b1);
    if (n >= 3000)
      report_and_stop;
    apb(1'b0, `EEP_OFS_CMD, 32'h0);
    check("soft loaded", q[10], 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    soft_reset_request_i <= 1'b0;
    @(posedge clk_i);
    t_autoload;
    t_write_read;
    t_bulk;
    t_timeout;
    t_reload;
    t_soft;
    report_and_stop;
  end
endmodule // test_serial_eeprom_host_access
